// file: hw/wl_train_pkg.sv
/*
 Constants for the write-levelization training block: field widths,
 reset values and cycle counts in memory clocks.
 Assumes one memory clock domain drives every register of the block.
*/
package wl_train_pkg;
    localparam int LANES = 9;
    localparam int DELAY_W = 8;
    localparam int MR_CS_W = 3;
    localparam int MR_BANK_W = 3;
    localparam int MR_ADDR_W = 16;
    localparam int ODT_W = 4;
    localparam int RATE_W = 3;
    localparam int DIMM_SEL_W = 2;
    localparam int ZQ_W = 2;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] MR_CMD_CYCLES = 8'h04;
    localparam logic [CNT_W-1:0] SR_ENTRY_CYCLES = 8'h08;
    localparam logic [CNT_W-1:0] SR_EXIT_CYCLES = 8'h08;
    localparam logic [CNT_W-1:0] RATE_CHANGE_CYCLES = 8'h10;
    localparam logic [CNT_W-1:0] LEVEL_STEP_CYCLES = 8'h08;
    localparam logic [DELAY_W-1:0] DELAY_RESET = 8'h00;
    localparam logic [RATE_W-1:0] RATE_RESET = 3'h0;
endpackage

// file: hw/wl_lane_level.sv
/*
 One byte lane leveling tracker: while training is active, steps the lane
 delay towards the edge where the sampled clock level changes.
 Assumes sample_i is the DQ feedback level taken by the phy.
*/
`timescale 1ns/100ps
`default_nettype none
module wl_lane_level (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [wl_train_pkg::DELAY_W-1:0] seed_i,
    input wire logic step_i,
    input wire logic sample_i,
    output logic [wl_train_pkg::DELAY_W-1:0] delay_o
);
    typedef struct packed {
        logic [wl_train_pkg::DELAY_W-1:0] delay;
        logic seen;
        logic last;
        logic done;
    } lane_state_t;
    lane_state_t s_q, s_d;
    always_comb begin
        s_d = s_q;
        if (load_i) begin
            s_d.delay = seed_i;
            s_d.seen = 1'b0;
            s_d.done = 1'b0;
        end else if (step_i && !s_q.done) begin
            // Stop on the first level change; low moves later, high earlier
            if (s_q.seen && (sample_i != s_q.last)) begin
                s_d.done = 1'b1;
            end else if (sample_i) begin
                s_d.delay = s_q.delay - 8'h01;
            end else begin
                s_d.delay = s_q.delay + 8'h01;
            end
            s_d.seen = 1'b1;
            s_d.last = sample_i;
        end
    end
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign delay_o = s_q.delay;
endmodule // wl_lane_level
`default_nettype wire

// file: hw/wl_train_ctrl.sv
/*
 Controller-side hardware of write-levelization training: mode-register
 command sender, self-refresh entry and exit, clock rate change and
 phy-assisted per-lane delay leveling.
 Assumes the configuring party sequences the fields as documented and
 holds the control inputs as levels between its writes.
*/
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Load chip select, bank, address, set send; hardware clears send when done.
// - Assist mode on 200 clocks (32 in pass two), then off; read delays.
// - Pass two sets self-refresh entry, waits for hardware to clear it.
// - Compensation off, rate invalid, new code, valid; wait pending clear, compensation on.
// - Set self-refresh exit; hardware clears it when done; then fence retraining.
// - Half-byte select picks lower or upper nibble (not decoded by this block); both results averaged.
module wl_train_ctrl (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic wl_train_enable_i,
    input wire logic [wl_train_pkg::DIMM_SEL_W-1:0] train_dimm_select_i,
    input wire logic [wl_train_pkg::MR_CS_W-1:0] modereg_cmd_chip_select_i,
    input wire logic [wl_train_pkg::MR_BANK_W-1:0] modereg_cmd_bank_i,
    input wire logic [wl_train_pkg::MR_ADDR_W-1:0] modereg_cmd_addr_i,
    input wire logic modereg_cmd_send_set_i,
    input wire logic [wl_train_pkg::ODT_W-1:0] wl_odt_pattern_i,
    input wire logic wl_odt_drive_en_i,
    input wire logic wl_phy_assist_mode_i,
    input wire logic train_half_byte_sel_i,
    input wire logic delay_write_i,
    input wire logic [wl_train_pkg::LANES*wl_train_pkg::DELAY_W-1:0] delay_seed_i,
    input wire logic [wl_train_pkg::LANES-1:0] lane_sample_i,
    input wire logic self_refresh_entry_set_i,
    input wire logic self_refresh_exit_set_i,
    input wire logic auto_comp_off_i,
    input wire logic [wl_train_pkg::RATE_W-1:0] mem_clock_rate_code_i,
    input wire logic mem_clock_rate_valid_i,
    output logic modereg_cmd_send_o,
    output logic mr_cmd_strobe_o,
    output logic [wl_train_pkg::MR_CS_W-1:0] mr_cmd_chip_select_o,
    output logic [wl_train_pkg::MR_BANK_W-1:0] mr_cmd_bank_o,
    output logic [wl_train_pkg::MR_ADDR_W-1:0] mr_cmd_addr_o,
    output logic [wl_train_pkg::ODT_W-1:0] odt_pins_o,
    output logic self_refresh_entry_o,
    output logic self_refresh_exit_o,
    output logic rate_change_pending_o,
    output logic [wl_train_pkg::RATE_W-1:0] active_rate_code_o,
    output logic comp_running_o,
    output logic [wl_train_pkg::LANES*wl_train_pkg::DELAY_W-1:0] lane_delay_o
);
    typedef enum logic [1:0] {
        RATE_IDLE = 2'b00,
        RATE_WAIT = 2'b01,
        RATE_DONE = 2'b10
    } rate_state_t;

    typedef struct packed {
        logic send;
        logic [wl_train_pkg::CNT_W-1:0] mr_cnt;
        logic strobe;
        logic [wl_train_pkg::MR_CS_W-1:0] cs;
        logic [wl_train_pkg::MR_BANK_W-1:0] bank;
        logic [wl_train_pkg::MR_ADDR_W-1:0] addr;
        logic [wl_train_pkg::ODT_W-1:0] odt;
        logic sr_entry;
        logic sr_exit;
        logic [wl_train_pkg::CNT_W-1:0] sr_cnt;
        rate_state_t rate_st;
        logic [wl_train_pkg::CNT_W-1:0] rate_cnt;
        logic pending;
        logic [wl_train_pkg::RATE_W-1:0] rate;
        logic valid_last;
        logic comp;
        logic [wl_train_pkg::CNT_W-1:0] step_cnt;
        logic [wl_train_pkg::LANES*wl_train_pkg::DELAY_W-1:0] delay_out;
    } ctrl_state_t;

    ctrl_state_t s_q, s_d;
    logic step;
    logic load;
    logic [wl_train_pkg::LANES*wl_train_pkg::DELAY_W-1:0] lane_delay;

    // Leveling steps only while the phy assist mode is on
    assign step = wl_train_enable_i && wl_phy_assist_mode_i
        && (s_q.step_cnt == wl_train_pkg::LEVEL_STEP_CYCLES);
    // Seeds loaded while assist mode is off
    assign load = delay_write_i && !wl_phy_assist_mode_i;

    // Lane samples come straight from lane_sample_i; train_half_byte_sel_i is not decoded here
    genvar g;
    generate
        for (g = 0; g < wl_train_pkg::LANES; g = g + 1) begin : g_lane
            wl_lane_level u_lane (
                .core_clk_i(core_clk_i),
                .rst_i(rst_i),
                .load_i(load),
                .seed_i(delay_seed_i[g*wl_train_pkg::DELAY_W +: wl_train_pkg::DELAY_W]),
                .step_i(step),
                .sample_i(lane_sample_i[g]),
                .delay_o(lane_delay[g*wl_train_pkg::DELAY_W +: wl_train_pkg::DELAY_W])
            );
        end
    endgenerate

    always_comb begin
        s_d = s_q;
        s_d.strobe = 1'b0;
        // Mode-register command: capture fields, issue, clear send when done
        if (s_q.send) begin
            if (s_q.mr_cnt == wl_train_pkg::MR_CMD_CYCLES) begin
                s_d.send = 1'b0;
                s_d.mr_cnt = '0;
                s_d.strobe = 1'b1;
            end else begin
                s_d.mr_cnt = s_q.mr_cnt + 8'h01;
            end
        end else if (modereg_cmd_send_set_i) begin
            s_d.send = 1'b1;
            s_d.cs = modereg_cmd_chip_select_i;
            s_d.bank = modereg_cmd_bank_i;
            s_d.addr = modereg_cmd_addr_i;
        end
        // Leveling ODT driven only while enabled
        s_d.odt = wl_odt_drive_en_i ? wl_odt_pattern_i : '0;
        // Self-refresh entry and exit, cleared by hardware when complete
        if (s_q.sr_entry || s_q.sr_exit) begin
            if (s_q.sr_cnt == (s_q.sr_entry ? wl_train_pkg::SR_ENTRY_CYCLES : wl_train_pkg::SR_EXIT_CYCLES)) begin
                s_d.sr_entry = 1'b0;
                s_d.sr_exit = 1'b0;
                s_d.sr_cnt = '0;
            end else begin
                s_d.sr_cnt = s_q.sr_cnt + 8'h01;
            end
        end else if (self_refresh_entry_set_i) begin
            s_d.sr_entry = 1'b1;
        end else if (self_refresh_exit_set_i) begin
            s_d.sr_exit = 1'b1;
        end
        // Rate change on rising valid edge
        s_d.valid_last = mem_clock_rate_valid_i;
        s_d.comp = !auto_comp_off_i;
        unique case (s_q.rate_st)
            RATE_IDLE: begin
                if (mem_clock_rate_valid_i && !s_q.valid_last) begin
                    s_d.pending = 1'b1;
                    s_d.rate_cnt = '0;
                    s_d.rate_st = RATE_WAIT;
                end
            end
            RATE_WAIT: begin
                if (s_q.rate_cnt == wl_train_pkg::RATE_CHANGE_CYCLES) begin
                    s_d.rate = mem_clock_rate_code_i;
                    s_d.rate_st = RATE_DONE;
                end else begin
                    s_d.rate_cnt = s_q.rate_cnt + 8'h01;
                end
            end
            RATE_DONE: begin
                s_d.pending = 1'b0;
                s_d.rate_st = RATE_IDLE;
            end
            default: begin
                s_d.rate_st = RATE_IDLE;
            end
        endcase
        // Step pacing while assist mode and training enable are both on
        // Restart from zero whenever leveling pauses so the first step comes a full period in
        if (!(wl_train_enable_i && wl_phy_assist_mode_i) || step) begin
            s_d.step_cnt = '0;
        end else begin
            s_d.step_cnt = s_q.step_cnt + 8'h01;
        end
        s_d.delay_out = lane_delay;
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.rate_st <= RATE_IDLE;
            s_q.rate <= wl_train_pkg::RATE_RESET;
            s_q.comp <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign modereg_cmd_send_o = s_q.send;
    assign mr_cmd_strobe_o = s_q.strobe;
    assign mr_cmd_chip_select_o = s_q.cs;
    assign mr_cmd_bank_o = s_q.bank;
    assign mr_cmd_addr_o = s_q.addr;
    assign odt_pins_o = s_q.odt;
    assign self_refresh_entry_o = s_q.sr_entry;
    assign self_refresh_exit_o = s_q.sr_exit;
    assign rate_change_pending_o = s_q.pending;
    assign active_rate_code_o = s_q.rate;
    assign comp_running_o = s_q.comp;
    assign lane_delay_o = s_q.delay_out;
endmodule // wl_train_ctrl
`default_nettype wire

// file: test/wl_train_checker.sv
/* Port assertions of the write-levelization training block.
 Assumes a bind onto wl_train_ctrl and a single clock domain. */
`timescale 1ns/100ps
`default_nettype none
module wl_train_checker (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic modereg_cmd_send_set_i,
    input wire logic [wl_train_pkg::MR_ADDR_W-1:0] modereg_cmd_addr_i,
    input wire logic [wl_train_pkg::ODT_W-1:0] wl_odt_pattern_i,
    input wire logic wl_odt_drive_en_i,
    input wire logic auto_comp_off_i,
    input wire logic mem_clock_rate_valid_i,
    input wire logic modereg_cmd_send_o,
    input wire logic mr_cmd_strobe_o,
    input wire logic [wl_train_pkg::MR_ADDR_W-1:0] mr_cmd_addr_o,
    input wire logic [wl_train_pkg::ODT_W-1:0] odt_pins_o,
    input wire logic self_refresh_entry_o,
    input wire logic self_refresh_exit_o,
    input wire logic rate_change_pending_o,
    input wire logic comp_running_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    property p_mr_take;
        modereg_cmd_send_set_i && !modereg_cmd_send_o |=> mr_cmd_addr_o == $past(modereg_cmd_addr_i);
    endproperty
    a_mr_take: assert property (p_mr_take) else $error("mode command fields not taken");
    property p_mr_done;
        $rose(modereg_cmd_send_o) |-> modereg_cmd_send_o[*5] ##1 (!modereg_cmd_send_o && mr_cmd_strobe_o);
    endproperty
    a_mr_done: assert property (p_mr_done) else $error("mode command send not cleared in time");
    property p_odt;
        1 |=> odt_pins_o == ($past(wl_odt_drive_en_i) ? $past(wl_odt_pattern_i) : 4'h0);
    endproperty
    a_odt: assert property (p_odt) else $error("odt pins differ from pattern");
    property p_sr_in;
        $rose(self_refresh_entry_o) |-> self_refresh_entry_o[*8] ##[1:2] !self_refresh_entry_o;
    endproperty
    a_sr_in: assert property (p_sr_in) else $error("self refresh entry not cleared");
    property p_sr_out;
        $rose(self_refresh_exit_o) |-> self_refresh_exit_o[*8] ##[1:2] !self_refresh_exit_o;
    endproperty
    a_sr_out: assert property (p_sr_out) else $error("self refresh exit not cleared");
    property p_rate_go;
        $rose(mem_clock_rate_valid_i) |=> rate_change_pending_o;
    endproperty
    a_rate_go: assert property (p_rate_go) else $error("rate change not pending");
    property p_rate_end;
        $rose(rate_change_pending_o) |-> rate_change_pending_o[*8] ##1 rate_change_pending_o[*8] ##[1:4]
            !rate_change_pending_o;
    endproperty
    a_rate_end: assert property (p_rate_end) else $error("rate change length wrong");
    property p_comp;
        1 |=> comp_running_o == !$past(auto_comp_off_i);
    endproperty
    a_comp: assert property (p_comp) else $error("compensation state wrong");
    c_mr: cover property (mr_cmd_strobe_o);
    c_rate: cover property ($fell(rate_change_pending_o));
    c_sr: cover property ($fell(self_refresh_exit_o));
endmodule // wl_train_checker
bind wl_train_ctrl wl_train_checker i_chk (.*);
`default_nettype wire

// file: test/wl_dimm_model.sv
/* Lane feedback model of the DRAM devices during leveling.
 Assumes a lane samples high once its delay reaches its edge point. */
`timescale 1ns/100ps
`default_nettype none
module wl_dimm_model (
    input wire logic [wl_train_pkg::LANES*wl_train_pkg::DELAY_W-1:0] delay_i,
    input wire logic [wl_train_pkg::LANES*wl_train_pkg::DELAY_W-1:0] lvl_pt_i,
    output logic [wl_train_pkg::LANES-1:0] sample_o
);
    always_comb begin
        for (int l = 0; l < wl_train_pkg::LANES; l++) begin
            sample_o[l] = delay_i[l*8+:8] >= lvl_pt_i[l*8+:8];
        end
    end
endmodule // wl_dimm_model
`default_nettype wire

// file: test/tb.sv
/* Self-checking bench of wl_train_ctrl with the lane feedback model.
 Assumes the design package; stimulus changes on the falling clock edge. */
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int W = wl_train_pkg::LANES * wl_train_pkg::DELAY_W;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic en, send_set, odt_en, assist, nib, dwr, sre, srx, coff, rval, send_o, strobe, sr_in, sr_out, pend, comp;
    logic [1:0] dsel;
    logic [2:0] cs, bank, rcode, mcs, mbank, arate;
    logic [15:0] addr, maddr;
    logic [3:0] odt, odt_o;
    logic [W-1:0] seed, ldly, pts;
    logic [wl_train_pkg::LANES-1:0] sample;
    int mismatches = 0;
    int checked = 0;
    int exp_q[$];
    int sum[9] = '{default: 0};
    int fin[9];
    wire logic [3:0] watch = {pend, sr_out, sr_in, strobe};
    wl_train_ctrl i_dut (.core_clk_i, .rst_i, .wl_train_enable_i(en), .train_dimm_select_i(dsel),
        .modereg_cmd_chip_select_i(cs), .modereg_cmd_bank_i(bank), .modereg_cmd_addr_i(addr),
        .modereg_cmd_send_set_i(send_set), .wl_odt_pattern_i(odt), .wl_odt_drive_en_i(odt_en),
        .wl_phy_assist_mode_i(assist), .train_half_byte_sel_i(nib), .delay_write_i(dwr), .delay_seed_i(seed),
        .lane_sample_i(sample), .self_refresh_entry_set_i(sre), .self_refresh_exit_set_i(srx),
        .auto_comp_off_i(coff), .mem_clock_rate_code_i(rcode), .mem_clock_rate_valid_i(rval),
        .modereg_cmd_send_o(send_o), .mr_cmd_strobe_o(strobe), .mr_cmd_chip_select_o(mcs),
        .mr_cmd_bank_o(mbank), .mr_cmd_addr_o(maddr), .odt_pins_o(odt_o), .self_refresh_entry_o(sr_in),
        .self_refresh_exit_o(sr_out), .rate_change_pending_o(pend), .active_rate_code_o(arate),
        .comp_running_o(comp), .lane_delay_o(ldly));
    wl_dimm_model i_dimm (.delay_i(ldly), .lvl_pt_i(pts), .sample_o(sample));
    task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run;
        if (mismatches == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask
    task automatic await(input int b, input logic lvl);
        for (int n = 0; n < 40 && watch[b] !== lvl; n++) cyc(1);
        if (watch[b] !== lvl) begin
            chk("wait", watch[b], lvl);
            complete_run();
        end
    endtask
    task automatic mr(input logic [21:0] f);
        {cs, bank, addr} = f;
        send_set = 1'b1;
        cyc(1);
        chk("send", send_o, 1);
        {cs, bank, addr} = ~f;
        cyc(1);
        send_set = 1'b0;
        await(0, 1'b1);
        chk("mr", {mcs, mbank, maddr}, f);
        chk("send", send_o, 0);
    endtask
    task automatic train(input int n, input bit up);
        for (int l = 0; l < 9; l++) exp_q.push_back(up ? pts[l*8+:8] : pts[l*8+:8] - 1);
        dwr = 1'b1;
        cyc(1);
        {dwr, assist} = 2'b01;
        cyc(20);
        chk("seed", ldly, seed);
        en = 1'b1;
        cyc(n);
        {en, assist} = 2'b00;
        cyc(3);
        for (int l = 0; l < 9; l++) chk("lane", ldly[l*8+:8], exp_q.pop_front());
    endtask
    task automatic level(input int n, input bit up);
        dsel = 2'($urandom);
        mr(22'($urandom));
        mr(22'($urandom));
        cyc(40);
        odt = 4'($urandom);
        odt_en = 1'b1;
        cyc(10);
        chk("odt", odt_o, odt);
        train(n, up);
        odt_en = 1'b0;
        cyc(10);
        chk("odt", odt_o, 4'h0);
        mr(22'($urandom));
    endtask
    initial begin
        forever #25 core_clk_i = ~core_clk_i;
    end
    initial begin
        {en, send_set, odt_en, assist, nib, dwr, sre, srx, coff, rval} = '0;
        {dsel, cs, bank, addr, odt, rcode, seed, pts} = '0;
        void'($urandom(30));
        cyc(3);
        rst_i = 1'b0;
        chk("reset", {comp, send_o, sr_in, sr_out, pend, odt_o, ldly}, {1'b1, 80'h0});
        for (int i = 0; i < 4; i++) begin
            dsel = 2'($urandom);
            nib = 1'(i);
            mr(22'($urandom));
            odt = 4'($urandom);
            odt_en = ~i[0];
            cyc(1);
            chk("odt", odt_o, odt_en ? odt : 4'h0);
        end
        for (int i = 0; i < 2; i++) begin
            nib = 1'(i);
            for (int l = 0; l < 9; l++) begin
                seed[l*8+:8] = 8'($urandom_range(120, 20));
                pts[l*8+:8] = seed[l*8+:8] + 8'($urandom_range(15, 1));
                sum[l] += pts[l*8+:8];
            end
            level(200, 1'b1);
        end
        {sre, srx} = 2'b11;
        cyc(1);
        {sre, srx} = 2'b00;
        chk("sr", {sr_in, sr_out}, 2'b10);
        await(1, 1'b0);
        coff = 1'b1;
        cyc(1);
        chk("comp", comp, 0);
        rcode = 3'($urandom_range(7, 1));
        rval = 1'b1;
        cyc(2);
        chk("pend", pend, 1);
        await(3, 1'b0);
        chk("rate", arate, rcode);
        coff = 1'b0;
        srx = 1'b1;
        cyc(1);
        srx = 1'b0;
        chk("comp", {comp, sr_out}, 2'b11);
        await(2, 1'b0);
        for (int l = 0; l < 9; l++) seed[l*8+:8] = 8'(sum[l] / 2 * 533 / 400);
        for (int d = 0; d < 2; d++) begin
            for (int l = 0; l < 9; l++) begin
                pts[l*8+:8] = seed[l*8+:8] - 8'($urandom_range(2, 1));
                if (d == 0) fin[l] = pts[l*8+:8] - 1;
            end
            level(32, 1'b0);
        end
        for (int l = 0; l < 9; l++) seed[l*8+:8] = 8'(fin[l]);
        dwr = 1'b1;
        cyc(1);
        dwr = 1'b0;
        cyc(2);
        chk("final", ldly, seed);
        complete_run();
    end
endmodule // tb
`default_nettype wire
